/* File: hw/sync_burst_sram_control.v */
/*
  Control front end of a synchronous pipelined burst SRAM: address
  capture under the two strobes, chip-select decode, burst counter,
  byte and global write qualification and data pin direction control.
  Assumes the controlling party drives all synchronous inputs from the
  same clk; output enable and burst order are pins and are synchronised.
*/
// Notes on behaviour
// - The address is captured only on an edge with a strobe low and all chip selects active.
// - The two low address bits seed a two-bit burst counter that makes the later low bits.
// - Byte lane selects are active low and write their lane only with byte write enable low.
// - A low global write writes every lane regardless of lane selects and byte write enable.
// - Within a burst the counter steps on each edge with advance low and holds otherwise.
// - The part is selected only when primary and expand-low selects are low and expand-high is high.
// - Output enable is active low: low drives the data pins, high tristates them for input.
// - The first read clock after a deselected state keeps the outputs tristated.
// - A sampled low advance steps the internally generated burst address.
// - A low processor strobe loads the address register and seeds the burst counter.
// - With both strobes low and the primary select low only the processor strobe is acted on.
// - A low controller strobe also captures the address and seeds the burst counter.
// - Outputs are tristated in write data phases, after leaving deselect, and while deselected.
`timescale 1ns/10ps
`include "sram_ctl_defines.vh"

module sync_burst_sram_control #(
  parameter ADDR_W = `SRAM_ADDR_W,
  parameter LANES  = `SRAM_LANES,
  parameter LANE_W = `SRAM_LANE_W
) (
  // Clock and reset
  input  wire                    clk,
  input  wire                    rst_n,
  // Address and strobes
  input  wire [ADDR_W-1:0]       addr,
  input  wire                    proc_addr_strobe_n,
  input  wire                    ctrl_addr_strobe_n,
  input  wire                    burst_advance_n,
  // Chip selects
  input  wire                    chip_sel_primary_n,
  input  wire                    chip_sel_expand_hi,
  input  wire                    chip_sel_expand_n,
  // Write controls
  input  wire                    byte_write_enable_n,
  input  wire [LANES-1:0]        byte_lane_select_n,
  input  wire                    global_write_n,
  // Pins from outside the clock domain
  input  wire                    output_enable_n,
  input  wire                    burst_order_sel,
  // Data pins
  input  wire [LANES*LANE_W-1:0] dq_i,
  output reg  [LANES*LANE_W-1:0] dq_o,
  output reg                     dq_oe,
  // Memory array side
  input  wire [LANES*LANE_W-1:0] mem_rdata,
  output reg  [ADDR_W-1:0]       mem_addr_q,
  output reg                     mem_rd_q,
  output reg  [LANES-1:0]        mem_wr_lane_q,
  output reg  [LANES*LANE_W-1:0] mem_wdata_q,
  output reg                     selected_q
);

  localparam CNT_W = `SRAM_CNT_W;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Output enable acts after three clocks rather than truly asynchronously;
  // the price of keeping every output on a flip-flop.
  reg                    oe_n_s1_q;
  reg                    oe_n_s2_q;
  reg                    order_s1_q;
  reg                    order_s2_q;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      oe_n_s1_q  <= `SRAM_PIN_HI_RST;
      oe_n_s2_q  <= `SRAM_PIN_HI_RST;
      order_s1_q <= `SRAM_ORDER_LINEAR;
      order_s2_q <= `SRAM_ORDER_LINEAR;
    end
    else
    begin
      oe_n_s1_q  <= output_enable_n;
      oe_n_s2_q  <= oe_n_s1_q;
      order_s1_q <= burst_order_sel;
      order_s2_q <= order_s1_q;
    end
  end

  // ----------------------------------------
  // Strobe and select decode
  // ----------------------------------------
  wire chip_sel;
  wire proc_start;
  wire ctrl_start;
  wire start;
  wire start_ok;
  wire deselect;

  assign chip_sel   = !chip_sel_primary_n && chip_sel_expand_hi
                      && !chip_sel_expand_n;
  assign proc_start = !proc_addr_strobe_n && !chip_sel_primary_n;
  assign ctrl_start = !ctrl_addr_strobe_n && !proc_start;
  assign start      = proc_start || ctrl_start;
  assign start_ok   = start && chip_sel;
  assign deselect   = start && !chip_sel;

  // ----------------------------------------
  // Burst state and upper address
  // ----------------------------------------
  reg                    active_q;
  reg                    active_d;
  reg                    desel_q;
  reg                    desel_d;
  reg [ADDR_W-1:0]       upper_q;
  reg [ADDR_W-1:0]       upper_d;
  wire                   step;
  wire [CNT_W-1:0]       low_next;

  assign step = active_q && !start && !burst_advance_n;

  always @*
  begin
    active_d = active_q;
    desel_d  = desel_q;
    upper_d  = upper_q;
    if (start_ok)
    begin
      active_d = 1'b1;
      desel_d  = 1'b0;
      upper_d  = addr;
    end
    else if (deselect)
    begin
      active_d = 1'b0;
      desel_d  = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      active_q <= `SRAM_BIT_RST;
      desel_q  <= 1'b1;
      upper_q  <= {ADDR_W{1'b0}};
    end
    else
    begin
      active_q <= active_d;
      desel_q  <= desel_d;
      upper_q  <= upper_d;
    end
  end

  burst_counter #(
    .CNT_W      (CNT_W)
  ) u_burst_counter (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (start_ok),
    .seed       (addr[CNT_W-1:0]),
    .step       (step),
    .interleave (order_s2_q == `SRAM_ORDER_INTERLEAVE),
    .low_next   (low_next)
  );

  // ----------------------------------------
  // Write qualification
  // ----------------------------------------
  // A processor-strobe start is always a read; writes follow on later edges.
  reg  [LANES-1:0]       lanes_d;
  wire                   wr_allowed;

  assign wr_allowed = active_d && !proc_start;

  always @*
  begin
    lanes_d = {LANES{1'b0}};
    if (wr_allowed)
    begin
      if (!global_write_n)
        lanes_d = {LANES{1'b1}};
      else if (!byte_write_enable_n)
        lanes_d = ~byte_lane_select_n;
    end
  end

  // ----------------------------------------
  // Access issue
  // ----------------------------------------
  reg                    rd_first_q;
  wire                   rd_d;

  assign rd_d = active_d && (lanes_d == {LANES{1'b0}});

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_addr_q    <= {ADDR_W{1'b0}};
      mem_rd_q      <= `SRAM_BIT_RST;
      mem_wr_lane_q <= `SRAM_LANE_RST;
      mem_wdata_q   <= {(LANES*LANE_W){1'b0}};
      selected_q    <= `SRAM_BIT_RST;
      rd_first_q    <= `SRAM_BIT_RST;
    end
    else
    begin
      mem_addr_q    <= {upper_d[ADDR_W-1:CNT_W], low_next};
      mem_rd_q      <= rd_d;
      mem_wr_lane_q <= lanes_d;
      if (lanes_d != {LANES{1'b0}})
        mem_wdata_q <= dq_i;
      selected_q    <= active_d;
      rd_first_q    <= rd_d && desel_q && start_ok;
    end
  end

  // ----------------------------------------
  // Data pin direction
  // ----------------------------------------
  // Read data is taken while mem_rd_q is high and driven the next cycle.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      dq_o  <= {(LANES*LANE_W){1'b0}};
      dq_oe <= `SRAM_BIT_RST;
    end
    else
    begin
      if (mem_rd_q)
        dq_o <= mem_rdata;
      dq_oe <= mem_rd_q && !rd_first_q && !oe_n_s2_q;
    end
  end

endmodule // sync_burst_sram_control

/* File: hw/sram_ctl_defines.vh */
/*
  Constants for the synchronous burst SRAM control front end: widths,
  reset values and the burst-order encoding.
  Assumes it is included by bare name from the design files under hw/.
*/
`ifndef SRAM_CTL_DEFINES_VH
`define SRAM_CTL_DEFINES_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SRAM_ADDR_W      19
`define SRAM_LANES       4
`define SRAM_LANE_W      9
`define SRAM_CNT_W       2

// ----------------------------------------
// Burst order select levels
// ----------------------------------------
`define SRAM_ORDER_LINEAR     1'h0
`define SRAM_ORDER_INTERLEAVE 1'h1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRAM_CNT_RST     2'h0
`define SRAM_LANE_RST    4'h0
`define SRAM_PIN_HI_RST  1'h1
`define SRAM_BIT_RST     1'h0

`endif

/* File: hw/burst_counter.v */
/*
  Two-bit burst address generator: holds the seed taken from the low
  address bits and an offset that steps on advance, and forms the low
  address in linear or interleaved order.
  Assumes load and step are never high together.
*/
`timescale 1ns/10ps
`include "sram_ctl_defines.vh"

module burst_counter #(
  parameter CNT_W = `SRAM_CNT_W
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Control
  input  wire             load,
  input  wire [CNT_W-1:0] seed,
  input  wire             step,
  input  wire             interleave,
  // Low address of the access taken at this edge
  output reg  [CNT_W-1:0] low_next
);

  reg  [CNT_W-1:0] base_q;
  reg  [CNT_W-1:0] offs_q;
  reg  [CNT_W-1:0] base_d;
  reg  [CNT_W-1:0] offs_d;

  // ----------------------------------------
  // Next seed and offset
  // ----------------------------------------
  always @*
  begin
    base_d = base_q;
    offs_d = offs_q;
    if (load)
    begin
      base_d = seed;
      offs_d = {CNT_W{1'b0}};
    end
    else if (step)
    begin
      // Offset wraps inside the four-location group
      offs_d = offs_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (interleave)
      low_next = base_d ^ offs_d;
    else
      low_next = base_d + offs_d;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      base_q <= `SRAM_CNT_RST;
      offs_q <= `SRAM_CNT_RST;
    end
    else
    begin
      base_q <= base_d;
      offs_q <= offs_d;
    end
  end

endmodule // burst_counter

/* File: testbench/sram_array_model.sv */
/*
  Memory array on the far side: word data is a pattern of its address.
  Assumes a registered address from the control block.
*/
`timescale 1ns/10ps
module sram_array_model (
  input  wire [18:0] mem_addr_q,
  output wire [35:0] mem_rdata
);
  // Inverted half: the low 18 bits are the complement of the high 18 bits
  assign mem_rdata = {mem_addr_q[17:0], ~mem_addr_q[17:0]};
endmodule // sram_array_model

/* File: testbench/sram_ctl_asserts.sv */
/*
  Port assertions for the burst SRAM control front end.
  Assumes default widths and a burst order held static within bursts.
*/
`timescale 1ns/10ps
module sram_ctl_asserts (
  input wire        clk,
  input wire        rst_n,
  input wire [18:0] addr,
  input wire        proc_addr_strobe_n,
  input wire        ctrl_addr_strobe_n,
  input wire        burst_advance_n,
  input wire        chip_sel_primary_n,
  input wire        chip_sel_expand_hi,
  input wire        chip_sel_expand_n,
  input wire        byte_write_enable_n,
  input wire [3:0]  byte_lane_select_n,
  input wire        global_write_n,
  input wire        output_enable_n,
  input wire        burst_order_sel,
  input wire        dq_oe,
  input wire [18:0] mem_addr_q,
  input wire        mem_rd_q,
  input wire [3:0]  mem_wr_lane_q,
  input wire        selected_q
);
  wire sel = !chip_sel_primary_n && chip_sel_expand_hi && !chip_sel_expand_n;
  wire ps  = !proc_addr_strobe_n && !chip_sel_primary_n;
  wire cs  = !ps && !ctrl_addr_strobe_n;
  reg  [16:0] base_q;
  reg  [1:0]  seed_q, offs_q;
  // Reference burst address, independent of the design's counter
  always @(posedge clk)
    if (!rst_n)
      offs_q <= 2'h0;
    else if (ps || cs)
      {base_q, seed_q, offs_q} <= {addr, 2'h0};
    else if (!burst_advance_n)
      offs_q <= offs_q + 2'h1;
  default clocking dflt @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence oe_on; (!output_enable_n) [*5]; endsequence
  AST_LOAD: assert property ((ps || cs) && sel |=> selected_q && mem_addr_q == $past(addr))
    else $error("address not captured");
  AST_DESEL: assert property ((ps || cs) && !sel |=> !selected_q)
    else $error("not deselected");
  AST_IGNORE: assert property (chip_sel_primary_n && !ps && !cs && selected_q
    && burst_advance_n |=> selected_q && $stable(mem_addr_q)) else $error("strobe not ignored");
  AST_BOTH: assert property (ps && sel && !ctrl_addr_strobe_n |=> mem_rd_q && !mem_wr_lane_q)
    else $error("controller strobe acted on");
  AST_LANES: assert property (cs && sel && global_write_n |=> mem_wr_lane_q ==
    ($past(byte_write_enable_n) ? 4'h0 : ~$past(byte_lane_select_n))) else $error("bad lanes");
  AST_GLOBAL: assert property (!global_write_n && !ps && (cs && sel || selected_q && !cs)
    |=> mem_wr_lane_q == 4'hf) else $error("global write missed");
  AST_BURST: assert property (selected_q |-> mem_addr_q == {base_q,
    burst_order_sel ? seed_q ^ offs_q : seed_q + offs_q}) else $error("bad burst address");
  AST_OE_MASK: assert property (dq_oe |-> $past(mem_rd_q) && $past(selected_q, 2))
    else $error("outputs driven out of a read");
  AST_OE_ON: assert property (oe_on ##0 (mem_rd_q && $past(selected_q)) |=> dq_oe)
    else $error("outputs not driven");
endmodule // sram_ctl_asserts
bind sync_burst_sram_control sram_ctl_asserts port_checks (.*);

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the burst SRAM control front end.
  Assumes the array model beside the design and the bound checker.
*/
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0, rst_n = 1'b0, proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1;
  reg burst_advance_n = 1'b1, chip_sel_primary_n = 1'b0, chip_sel_expand_hi = 1'b1;
  reg chip_sel_expand_n = 1'b0, byte_write_enable_n = 1'b1, global_write_n = 1'b1;
  reg output_enable_n = 1'b0, burst_order_sel = 1'b0;
  reg  [18:0] addr = 19'h0_0000;
  reg  [3:0]  byte_lane_select_n = 4'hf;
  reg  [35:0] dq_i = 36'h9_8765_4321;
  wire [35:0] dq_o, mem_rdata, mem_wdata_q;
  wire [18:0] mem_addr_q;
  wire [3:0]  mem_wr_lane_q;
  wire        dq_oe, mem_rd_q, selected_q;
  integer     error_cnt = 0, num_checks = 0;
  sync_burst_sram_control uut (.*);
  sram_array_model mem (.*);
  initial forever #2.5 clk = ~clk;
  // All steps are fixed counts; this only guards against a stuck run
  initial
  begin
    #20000 error_cnt = error_cnt + 1;
    test_done;
  end
  task tick;
  begin
    @(posedge clk);
    @(negedge clk);
  end
  endtask
  task chk(input [63:0] seen, input [63:0] exp);
  begin
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  end
  endtask
  task go(input p, input [18:0] a);
  begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, addr} = {!p, p, a};
    tick;
    {proc_addr_strobe_n, ctrl_addr_strobe_n} = 2'h3;
  end
  endtask
  // Edge on both ends so no select or strobe is driven twice in one step
  task desel(input [2:0] ce);
  begin
    tick;
    {chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_n} = ce;
    go(1'b0, 19'h0_0000);
    chk(selected_q, 1'b0);
    {chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_n} = 3'h2;
    tick;
  end
  endtask
  task t_burst(input ord);
    integer k;
    reg [1:0]  low;
    reg [18:0] prev;
  begin
    desel(3'h6);
    burst_order_sel = ord;
    repeat (3) tick;
    go(1'b1, 19'h1_2341);
    chk(mem_addr_q, 19'h1_2341);
    chk(mem_addr_q[1:0], 2'h1);
    burst_advance_n = 1'b0;
    for (k = 1; k < 5; k = k + 1)
    begin
      prev = mem_addr_q;
      tick;
      low = ord ? 2'h1 ^ k[1:0] : 2'h1 + k[1:0];
      chk(mem_addr_q, {17'h0_48d0, low});
      chk(dq_oe, k > 1);
      chk(dq_o, {prev[17:0], ~prev[17:0]});
    end
    burst_advance_n = 1'b1;
    {chip_sel_primary_n, proc_addr_strobe_n} = 2'h2;
    tick;
    chk(mem_addr_q, {17'h0_48d0, low});
    chk(selected_q, 1'b1);
    {chip_sel_primary_n, proc_addr_strobe_n} = 2'h1;
    // Suspended burst keeps reading; output enable lags the pin by three edges
    output_enable_n = 1'b1;
    repeat (3) tick;
    chk(dq_oe, 1'b0);
    output_enable_n = 1'b0;
    repeat (3) tick;
    chk(dq_oe, 1'b1);
    $display("burst test done, order %0d", ord);
  end
  endtask
  task t_write;
  begin
    desel(3'h0);
    desel(3'h3);
    {byte_write_enable_n, byte_lane_select_n} = 5'h0e;
    go(1'b0, 19'h0_0100);
    chk(mem_addr_q, 19'h0_0100);
    chk(mem_wr_lane_q, 4'h1);
    chk(mem_wdata_q, 36'h9_8765_4321);
    chk(mem_rd_q, 1'b0);
    byte_write_enable_n = 1'b1;
    tick;
    chk(mem_wr_lane_q, 4'h0);
    global_write_n = 1'b0;
    dq_i = 36'h1_2345_6789;
    tick;
    chk(mem_wr_lane_q, 4'hf);
    chk(mem_wdata_q, 36'h1_2345_6789);
    {proc_addr_strobe_n, ctrl_addr_strobe_n} = 2'h0;
    tick;
    chk(mem_rd_q, 1'b1);
    chk(mem_wr_lane_q, 4'h0);
    chk(dq_oe, 1'b0);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n} = 3'h7;
    $display("write test done");
  end
  endtask
  task test_done;
  begin
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    tick;
    t_burst(1'b0);
    t_burst(1'b1);
    t_write;
    test_done;
  end
endmodule // testbench
